// >>> design/prr_regs.sv
// Port remap register and shutdown priority registers with fast-shutdown decision
//
// Overview of operation
// - After reset the remap register holds identity mapping, top field code 11.
// - A remap write with a duplicated physical code is ignored entirely.
// - The IC reset command clears other registers but keeps the remap register.
// - Code 27h byte: port 2 priority bits 6-4, port 1 bits 2-0, reset 0.
// - Code 28h byte: port 4 priority bits 6-4, port 3 bits 2-0, reset 0.
// - In three-bit mode a port turns off when shutdown code is at most its priority, except in the cycle after an IC reset command.
// - Priority shutdown clears port bits like a port reset, keeping cool-down counts.
`include "prr_defs.svh"
`default_nettype none
module prr_regs
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register command port
  input  wire prr_pkg::prr_cmd_s cmd,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  // Fast-shutdown input
  input  wire logic             three_bit_priority_select,
  input  wire logic             shut_valid,
  input  wire logic [2:0]       shut_code,
  // Shutdown results and remap register value
  output logic [3:0]            port_off,
  output logic [7:0]            remap
);
  typedef enum logic [1:0] {
    PRR_RUN   = 2'b01,
    PRR_RESET = 2'b10
  } prr_state_e;

  logic            rst_m_q;
  logic            rst_s_q;
  logic [7:0]      remap_q;
  logic [7:0]      remap_d;
  logic [7:0]      prio12_q;
  logic [7:0]      prio12_d;
  logic [7:0]      prio34_q;
  logic [7:0]      prio34_d;
  logic [7:0]      rd_data_q;
  logic [7:0]      rd_data_d;
  logic            rd_valid_q;
  logic            rd_valid_d;
  logic [3:0]      off_q;
  logic [3:0]      off_d;
  prr_state_e      st_q;
  prr_state_e      st_d;
  logic [3:0]      hit;
  prr_pkg::prr_prio_t prio [4];

  // Returns high when any two 2-bit fields share a physical code
  function automatic logic has_dup(input logic [7:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++)
      for (int j = i + 1; j < 4; j++)
        if (v[2*i +: 2] == v[2*j +: 2])
          r = 1'b1;
    return r;
  endfunction

  // Reset release synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Priority fields per port
  assign prio[0] = prio12_q[`PRR_LO_PRIO_LSB +: `PRR_PRIO_W];
  assign prio[1] = prio12_q[`PRR_HI_PRIO_LSB +: `PRR_PRIO_W];
  assign prio[2] = prio34_q[`PRR_LO_PRIO_LSB +: `PRR_PRIO_W];
  assign prio[3] = prio34_q[`PRR_HI_PRIO_LSB +: `PRR_PRIO_W];

  // Comparators, one per port
  for (genvar p = 0; p < `PRR_NPORTS; p++)
  begin : g_cmp
    prr_shut_cmp u_cmp
    (
      .code (shut_code),
      .prio (prio[p]),
      .hit  (hit[p])
    );
  end

  // Next-state of registers and command handling
  always_comb
  begin
    remap_d    = remap_q;
    prio12_d   = prio12_q;
    prio34_d   = prio34_q;
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    off_d      = 4'h0;
    st_d       = PRR_RUN;
    case (st_q)
      PRR_RUN:
      begin
        if (cmd.wr)
        begin
          case (cmd.code)
            `PRR_CMD_IC_RESET:
            begin
              prio12_d = `PRR_PRIO_RST;
              prio34_d = `PRR_PRIO_RST;
              st_d     = PRR_RESET;
            end
            `PRR_CMD_PRIO_12: prio12_d = cmd.data & `PRR_PRIO_MASK;
            `PRR_CMD_PRIO_34: prio34_d = cmd.data & `PRR_PRIO_MASK;
            `PRR_CMD_REMAP:
            begin
              if (!has_dup(cmd.data))
                remap_d = cmd.data;
            end
            default: ;
          endcase
        end
        else if (cmd.rd)
        begin
          rd_valid_d = 1'b1;
          case (cmd.code)
            `PRR_CMD_PRIO_12: rd_data_d = prio12_q;
            `PRR_CMD_PRIO_34: rd_data_d = prio34_q;
            `PRR_CMD_REMAP:   rd_data_d = remap_q;
            default:          rd_data_d = 8'h00;
          endcase
        end
        // One-cycle turn-off request; cool-down counters lie outside and are untouched
        if (three_bit_priority_select && shut_valid)
          off_d = hit;
      end
      PRR_RESET: st_d = PRR_RUN;
      default:   st_d = PRR_RUN;
    endcase
  end

  // Register update
  always_ff @(posedge clk or negedge rst_s_q)
  begin
    if (!rst_s_q)
    begin
      remap_q    <= `PRR_REMAP_RST;
      prio12_q   <= `PRR_PRIO_RST;
      prio34_q   <= `PRR_PRIO_RST;
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
      off_q      <= 4'h0;
      st_q       <= PRR_RUN;
    end
    else
    begin
      remap_q    <= remap_d;
      prio12_q   <= prio12_d;
      prio34_q   <= prio34_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      off_q      <= off_d;
      st_q       <= st_d;
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign port_off = off_q;
  assign remap    = remap_q;

  AST_REMAP_DUP: assert property (@(posedge clk) disable iff (!rst_s_q)
    (cmd.wr && cmd.code == `PRR_CMD_REMAP && has_dup(cmd.data)) |=> $stable(remap_q))
    else $error("duplicate remap write changed mapping");
  AST_IC_KEEP: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && cmd.wr && cmd.code == `PRR_CMD_IC_RESET)
      |=> ($stable(remap_q) && prio12_q == 8'h00 && prio34_q == 8'h00))
    else $error("ic reset mishandled registers");
  AST_P12_WR: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && cmd.wr && cmd.code == `PRR_CMD_PRIO_12)
      |=> prio12_q == ($past(cmd.data) & 8'h77))
    else $error("port 1/2 priority write wrong");
  AST_P34_WR: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && cmd.wr && cmd.code == `PRR_CMD_PRIO_34)
      |=> prio34_q == ($past(cmd.data) & 8'h77))
    else $error("port 3/4 priority write wrong");
  AST_OFF_P1: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && three_bit_priority_select && shut_valid)
      |=> port_off[0] == ($past(shut_code) <= $past(prio12_q[2:0])))
    else $error("port 1 shutdown decision wrong");
  AST_OFF_P4: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && three_bit_priority_select && shut_valid)
      |=> port_off[3] == ($past(shut_code) <= $past(prio34_q[6:4])))
    else $error("port 4 shutdown decision wrong");
  AST_OFF_IDLE: assert property (@(posedge clk) disable iff (!rst_s_q)
    !(three_bit_priority_select && shut_valid) |=> port_off == 4'h0)
    else $error("turn-off without shutdown code");
  AST_RD_P12: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && !cmd.wr && cmd.rd && cmd.code == `PRR_CMD_PRIO_12)
      |=> (rd_valid && rd_data == $past(prio12_q)))
    else $error("port 1/2 read wrong");

  // A read of one register code taken in the run state
  sequence s_rd_cmd(logic [7:0] c);
    st_q == PRR_RUN && !cmd.wr && cmd.rd && cmd.code == c;
  endsequence
  AST_RD_P34: assert property (@(posedge clk) disable iff (!rst_s_q)
    s_rd_cmd(`PRR_CMD_PRIO_34) |=> (rd_valid && rd_data == $past(prio34_q)))
    else $error("port 3/4 read wrong");
  AST_OFF_SEL_LOW: assert property (@(posedge clk) disable iff (!rst_s_q)
    !three_bit_priority_select |=> port_off == 4'h0)
    else $error("turn-off outside three-bit mode");
  AST_REMAP_OK: assert property (@(posedge clk) disable iff (!rst_s_q)
    (st_q == PRR_RUN && cmd.wr && cmd.code == `PRR_CMD_REMAP && !has_dup(cmd.data))
      |=> remap_q == $past(cmd.data))
    else $error("valid remap write not taken");
endmodule
`default_nettype wire

// >>> design/prr_defs.svh
// Offsets, field positions, reset values and codes for the remap and priority registers
`ifndef PRR_DEFS_SVH
`define PRR_DEFS_SVH
`define PRR_CMD_IC_RESET    8'h1a
`define PRR_CMD_PRIO_12     8'h27
`define PRR_CMD_PRIO_34     8'h28
`define PRR_CMD_REMAP       8'h26
`define PRR_REMAP_RST       8'he4
`define PRR_PRIO_RST        8'h00
`define PRR_PRIO_MASK       8'h77
`define PRR_LO_PRIO_LSB     0
`define PRR_HI_PRIO_LSB     4
`define PRR_PRIO_W          3
`define PRR_NPORTS          4
`endif

// >>> design/prr_pkg.sv
// Types shared by the remap and priority register logic
`default_nettype none
package prr_pkg;
  // One register command from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [7:0] data;
  } prr_cmd_s;
  typedef logic [2:0] prr_prio_t;
endpackage
`default_nettype wire

// >>> design/prr_shut_cmp.sv
// Per-port fast-shutdown comparison against a three-bit priority
`include "prr_defs.svh"
`default_nettype none
module prr_shut_cmp
(
  // Shutdown code and priority
  input  wire logic [2:0] code,
  input  wire logic [2:0] prio,
  // Result
  output logic            hit
);
  // Port goes off when the code does not exceed its priority
  assign hit = (code <= prio);
endmodule
`default_nettype wire

// >>> bench/prr_host.sv
// Host controller model that issues register commands
`default_nettype none
module prr_host
(
  // Clock
  input  wire logic             clk,
  // Command toward the register block
  output var prr_pkg::prr_cmd_s cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle command at time zero
  initial cmd = '0;
  // Write held for exactly one taking edge
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk);
    cmd <= '{wr: 1'b1, rd: 1'b0, code: code, data: data};
    @(posedge clk);
    cmd <= '0;
  endtask
  // Read held for one taking edge; answer is judged by the bench
  task automatic rd(input logic [7:0] code);
    @(posedge clk);
    cmd <= '{wr: 1'b0, rd: 1'b1, code: code, data: 8'h00};
    @(posedge clk);
    cmd <= '0;
  endtask
  // No port turn-on command exists here, so a remap is never followed by power-up
endmodule
`default_nettype wire

// >>> bench/prr_regs_test.sv
// Self-checking bench for the remap and priority registers
`include "prr_defs.svh"
`default_nettype none
module prr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  prr_pkg::prr_cmd_s cmd;
  logic [7:0]       rd_data;
  logic             rd_valid;
  logic             sel = 1'b1;
  logic             shut_valid = 1'b0;
  logic [2:0]       shut_code = 3'h0;
  logic [3:0]       port_off;
  logic [7:0]       remap;
  int               n_mismatch = 0;
  int               n_tests = 0;
  // Design and host
  prr_regs i_prr_regs (.clk(clk), .rstn(rstn), .cmd(cmd), .rd_data(rd_data),
    .rd_valid(rd_valid), .three_bit_priority_select(sel), .shut_valid(shut_valid),
    .shut_code(shut_code), .port_off(port_off), .remap(remap));
  prr_host i_prr_host (.clk(clk), .cmd(cmd));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  // Compare and count
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Read a register and judge the one-cycle answer
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
    i_prr_host.rd(code);
    #1;
    chk("rd_valid", {7'h0, rd_valid}, 8'h01);
    chk("rd_data", rd_data, exp);
  endtask
  // Reset values
  task automatic t_reset();
    #1 chk("remap", remap, 8'he4);
    rd_chk(`PRR_CMD_REMAP, 8'he4);
    rd_chk(`PRR_CMD_PRIO_12, 8'h00);
    rd_chk(`PRR_CMD_PRIO_34, 8'h00);
    $display("test reset done");
  endtask
  // Field packing, unused bits read zero
  task automatic t_prio();
    i_prr_host.wr(`PRR_CMD_PRIO_12, 8'hff);
    i_prr_host.wr(`PRR_CMD_PRIO_34, 8'h35);
    rd_chk(`PRR_CMD_PRIO_12, 8'h77);
    rd_chk(`PRR_CMD_PRIO_34, 8'h35);
    $display("test prio done");
  endtask
  // Duplicate remap rejected, valid one taken, kept over IC reset
  task automatic t_remap();
    i_prr_host.wr(`PRR_CMD_REMAP, 8'he5);
    #1 chk("remap", remap, 8'he4);
    i_prr_host.wr(`PRR_CMD_REMAP, 8'h1b);
    #1 chk("remap", remap, 8'h1b);
    i_prr_host.wr(`PRR_CMD_IC_RESET, 8'h00);
    #1 chk("remap", remap, 8'h1b);
    rd_chk(`PRR_CMD_REMAP, 8'h1b);
    rd_chk(`PRR_CMD_PRIO_12, 8'h00);
    rd_chk(`PRR_CMD_PRIO_34, 8'h00);
    $display("test remap done");
  endtask
  // Every shutdown code against mixed priorities
  task automatic t_shut();
    logic [3:0] exp;
    i_prr_host.wr(`PRR_CMD_PRIO_12, 8'h20);
    i_prr_host.wr(`PRR_CMD_PRIO_34, 8'h57);
    for (int c = 0; c < 8; c++)
    begin
      exp = {3'(c) <= 3'h5, 3'(c) <= 3'h7, 3'(c) <= 3'h2, 3'(c) == 3'h0};
      @(posedge clk);
      shut_valid <= 1'b1;
      shut_code <= 3'(c);
      @(posedge clk);
      shut_valid <= 1'b0;
      #1 chk("port_off", {4'h0, port_off}, {4'h0, exp});
      @(posedge clk);
      #1 chk("port_off", {4'h0, port_off}, 8'h00);
    end
    // Code zero with three-bit mode off must leave every port alone
    @(posedge clk);
    sel <= 1'b0;
    shut_valid <= 1'b1;
    shut_code <= 3'h0;
    @(posedge clk);
    shut_valid <= 1'b0;
    sel <= 1'b1;
    #1 chk("port_off", {4'h0, port_off}, 8'h00);
    rd_chk(`PRR_CMD_PRIO_34, 8'h57);
    $display("test shut done");
  endtask
  // Verdict
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #200us;
    n_mismatch++;
    close_out();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_prio();
    t_remap();
    t_shut();
    close_out();
  end
endmodule
`default_nettype wire
